// >>> hw/host_port_defines.svh
// host port constants: timing counts, widths, reset values
// assumes inclusion by bare name from hw/ sources
`ifndef HOST_PORT_DEFINES_SVH
`define HOST_PORT_DEFINES_SVH

// input clock period in ns
`define CORE_CLK_PERIOD_NS   4
// fixed slave wait states, counted in bus states
`define SLAVE_WAIT_STATES    2
// rising edges of the input clock after reset release before phase one
`define PHASE_START_EDGE     3
// least reset width in input clock cycles
`define RESET_MIN_CYCLES     5
// data and address widths
`define DATA_WIDTH           32
`define ADDR_WIDTH           32
`define LANES                4
// byte enables idle value, active low
`define BE_IDLE              4'hF
`define BE_ALL               4'h0

`endif

// >>> hw/host_port_pkg.sv
// host port types: transfer request, master bus outputs, lane data word
// assumes host_port_defines.svh sets the widths
`include "host_port_defines.svh"

package host_port_pkg;

  typedef struct packed {
    logic [`ADDR_WIDTH-1:0] byte_addr;
    logic [15:0]            byte_count;
    logic                   write;
  } xfer_req_type;

  typedef struct packed {
    logic [`ADDR_WIDTH-1:0] addr;
    logic [`LANES-1:0]      be_n;
    logic [`DATA_WIDTH-1:0] wdata;
    logic                   write;
  } master_bus_type;

  typedef struct packed {
    logic [`DATA_WIDTH-1:0] data;
    logic [`LANES-1:0]      be_n;
  } lane_word_type;

endpackage : host_port_pkg

// >>> hw/phase_gen.sv
// two-phase clock-enable generator from the double-rate input clock
// assumes reset release is already synchronous to i_core_clk
`timescale 1ns/1ns
`default_nettype none
`include "host_port_defines.svh"

module phase_gen (
  // clock and reset
  input  wire logic i_core_clk,
  input  wire logic i_rstn,
  // phase enables
  output logic      o_phase1,
  output logic      o_phase2
);

  logic [1:0] start_cnt_ff;
  logic [1:0] nxt_start_cnt;
  logic       run_ff;
  logic       nxt_run;
  logic       ph_ff;
  logic       nxt_ph;

  always_comb begin
    nxt_start_cnt = start_cnt_ff;
    nxt_run       = run_ff;
    nxt_ph        = ph_ff;
    if (!run_ff) begin
      nxt_start_cnt = start_cnt_ff + 2'd1;
      if (start_cnt_ff == 2'(`PHASE_START_EDGE - 2)) begin  // [RULE8]
        nxt_run = 1'b1;
        nxt_ph  = 1'b0;
      end
    end else begin
      nxt_ph = ~ph_ff;  // [RULE6]
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      start_cnt_ff <= 2'd0;
      run_ff       <= 1'b0;
      ph_ff        <= 1'b0;
    end else begin
      start_cnt_ff <= nxt_start_cnt;
      run_ff       <= nxt_run;
      ph_ff        <= nxt_ph;
    end
  end

  assign o_phase1 = run_ff & ph_ff;
  assign o_phase2 = run_ff & ~ph_ff;

endmodule : phase_gen
`default_nettype wire

// >>> hw/lane_align.sv
// splits a byte-aligned transfer into longword-aligned lane groups
// assumes i_addr and i_left are advanced by o_nbytes one beat at a time
`timescale 1ns/1ns
`default_nettype none
`include "host_port_defines.svh"

module lane_align #(
  parameter int ADDR_W = `ADDR_WIDTH
) (
  // current position
  input  wire logic [ADDR_W-1:0] i_addr,
  input  wire logic [15:0]       i_left,
  // lane group for this beat
  output logic [ADDR_W-1:0]      o_word_addr,
  output logic [`LANES-1:0]      o_be_n,
  output logic [2:0]             o_nbytes
);

  logic [2:0] room;

  always_comb begin
    room        = 3'd4 - {1'b0, i_addr[1:0]};
    o_nbytes    = (i_left < 16'(room)) ? i_left[2:0] : room;  // [RULE14]
    o_word_addr = {i_addr[ADDR_W-1:2], 2'b00};  // [RULE11]
    for (int i = 0; i < `LANES; i++) begin
      o_be_n[i] = !((i >= int'(i_addr[1:0])) && (i < int'(i_addr[1:0]) + int'(o_nbytes)));
    end
  end

endmodule : lane_align
`default_nettype wire

// >>> hw/host_bus_port.sv
// host memory-bus port: register slave handshake and fetch/move master
// assumes synchronous inputs, reset released in step with the host
// Contract
// [RULE1] slave inserts fixed wait states before ready
// [RULE2] slave write data captured on ready edge
// [RULE3] master waits in second state for ready
// [RULE4] slave samples ready input as host sees
// [RULE5] ready output synchronous, no external synchroniser
// [RULE6] halve input clock into two phases
// [RULE7] host holds reset five input clocks
// [RULE8] first phase one on third edge
// [RULE9] external phase clock high in phase one
// [RULE10] host synchronises reset through two flops
// [RULE11] longword addresses with four byte enables
// [RULE12] ignore data on disabled byte lanes
// [RULE13] script fetches start on longword boundaries
// [RULE14] unaligned head, full words, short tail
// [RULE15] drive bus only after grant acknowledge
// [RULE16] release bus and hold when done
`timescale 1ns/1ns
`default_nettype none
`include "host_port_defines.svh"

module host_bus_port #(
  parameter int WAITS = `SLAVE_WAIT_STATES
) (
  // clock and reset
  input  wire logic                          i_core_clk,
  input  wire logic                          i_rstn,
  // slave side
  input  wire logic                          i_slave_sel,
  input  wire logic                          i_slave_write,
  input  wire logic [`LANES-1:0]             i_slave_be_n,
  input  wire logic [`DATA_WIDTH-1:0]        i_bus_rdata,
  input  wire logic [`DATA_WIDTH-1:0]        i_reg_rdata,
  input  wire logic                          i_ready_in,
  output logic                               o_ready_out,
  output host_port_pkg::lane_word_type       o_slave_wr,
  output logic                               o_slave_wr_stb,
  // master arbitration
  output logic                               o_hold_req,
  input  wire logic                          i_bus_grant_ack,
  // master bus
  output host_port_pkg::master_bus_type      o_mbus,
  output logic                               o_mbus_oe_n,
  output logic                               o_addr_strobe,
  output logic [`DATA_WIDTH-1:0]             o_slave_rdata,
  // internal transfer request
  input  wire logic                          i_xfer_start,
  input  wire host_port_pkg::xfer_req_type   i_xfer,
  input  wire logic [`DATA_WIDTH-1:0]        i_xfer_wdata,
  output logic                               o_xfer_busy,
  output host_port_pkg::lane_word_type       o_rd_word,
  output logic                               o_rd_stb,
  output logic                               o_phase_clk
);

  typedef enum logic [2:0] {M_IDLE, M_HOLD, M_T1, M_T2, M_REL} mst_state_type;
  typedef enum logic [1:0] {S_IDLE, S_WAIT, S_DONE} slv_state_type;

  logic phase1;
  logic phase2;

  phase_gen u_phase (
    .i_core_clk (i_core_clk),
    .i_rstn     (i_rstn),
    .o_phase1   (phase1),
    .o_phase2   (phase2)
  );

  // slave: fixed wait states, then ready
  slv_state_type                 slv_ff, nxt_slv;
  logic [3:0]                    wait_ff, nxt_wait;
  logic                          rdy_ff, nxt_rdy;
  host_port_pkg::lane_word_type  swr_ff, nxt_swr;
  logic                          swr_stb_ff, nxt_swr_stb;
  logic [`DATA_WIDTH-1:0]        srd_ff, nxt_srd;

  always_comb begin
    nxt_slv     = slv_ff;
    nxt_wait    = wait_ff;
    nxt_rdy     = 1'b0;
    nxt_swr     = swr_ff;
    nxt_swr_stb = 1'b0;
    nxt_srd     = srd_ff;
    unique case (slv_ff)
      S_IDLE: begin
        if (i_slave_sel && phase1) begin
          nxt_slv  = S_WAIT;
          nxt_wait = 4'(WAITS);
        end
      end
      S_WAIT: begin
        if (phase2) begin
          if (wait_ff == 4'd0) begin
            nxt_rdy = 1'b1;  // [RULE1] [RULE5]
            nxt_slv = S_DONE;
            if (i_slave_write) begin
              nxt_swr_stb = 1'b1;  // [RULE2]
              nxt_swr.be_n = i_slave_be_n;
              for (int i = 0; i < `LANES; i++) begin
                nxt_swr.data[8*i +: 8] = i_slave_be_n[i] ? swr_ff.data[8*i +: 8]
                                                         : i_bus_rdata[8*i +: 8];  // [RULE12]
              end
            end else begin
              nxt_srd = i_reg_rdata;
            end
          end else begin
            nxt_wait = wait_ff - 4'd1;
          end
        end
      end
      S_DONE: begin
        if (i_ready_in || !i_slave_sel) begin
          nxt_slv = S_IDLE;  // [RULE4]
        end
      end
      default: nxt_slv = S_IDLE;
    endcase
  end

  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      slv_ff     <= S_IDLE;
      wait_ff    <= 4'd0;
      rdy_ff     <= 1'b0;
      swr_ff     <= '0;
      swr_stb_ff <= 1'b0;
      srd_ff     <= '0;
    end else begin
      slv_ff     <= nxt_slv;
      wait_ff    <= nxt_wait;
      rdy_ff     <= nxt_rdy;
      swr_ff     <= nxt_swr;
      swr_stb_ff <= nxt_swr_stb;
      srd_ff     <= nxt_srd;
    end
  end

  // master: hold, grant, first/second bus states, release
  mst_state_type                  mst_ff, nxt_mst;
  logic [`ADDR_WIDTH-1:0]         addr_ff, nxt_addr;
  logic [15:0]                    left_ff, nxt_left;
  logic                           wr_ff, nxt_wr;
  logic                           hold_ff, nxt_hold;
  logic                           oe_n_ff, nxt_oe_n;
  logic                           ads_ff, nxt_ads;
  host_port_pkg::master_bus_type  mbus_ff, nxt_mbus;
  host_port_pkg::lane_word_type   rdw_ff, nxt_rdw;
  logic                           rd_stb_ff, nxt_rd_stb;
  logic [`ADDR_WIDTH-1:0]         beat_addr;
  logic [`LANES-1:0]              beat_be_n;
  logic [2:0]                     beat_n;

  lane_align u_align (
    .i_addr      (addr_ff),
    .i_left      (left_ff),
    .o_word_addr (beat_addr),
    .o_be_n      (beat_be_n),
    .o_nbytes    (beat_n)
  );

  always_comb begin
    nxt_mst    = mst_ff;
    nxt_addr   = addr_ff;
    nxt_left   = left_ff;
    nxt_wr     = wr_ff;
    nxt_hold   = hold_ff;
    nxt_oe_n   = oe_n_ff;
    nxt_ads    = 1'b0;
    nxt_mbus   = mbus_ff;
    nxt_rdw    = rdw_ff;
    nxt_rd_stb = 1'b0;
    unique case (mst_ff)
      M_IDLE: begin
        if (i_xfer_start && i_xfer.byte_count != 16'd0) begin
          nxt_mst  = M_HOLD;
          nxt_addr = i_xfer.byte_addr;
          nxt_left = i_xfer.byte_count;
          nxt_wr   = i_xfer.write;
          nxt_hold = 1'b1;  // [RULE15]
        end
      end
      M_HOLD: begin
        if (i_bus_grant_ack && phase2) begin
          nxt_mst  = M_T1;  // [RULE15]
          nxt_oe_n = 1'b0;
        end
      end
      M_T1: begin
        if (phase2) begin
          nxt_mst        = M_T2;
          nxt_ads        = 1'b1;
          nxt_mbus.addr  = beat_addr;  // [RULE11]
          nxt_mbus.be_n  = beat_be_n;
          nxt_mbus.write = wr_ff;
          nxt_mbus.wdata = i_xfer_wdata;
        end
      end
      M_T2: begin
        if (phase2 && i_ready_in) begin  // [RULE3]
          nxt_addr = addr_ff + `ADDR_WIDTH'(beat_n);  // [RULE14]
          nxt_left = left_ff - 16'(beat_n);
          if (!wr_ff) begin
            nxt_rd_stb  = 1'b1;
            nxt_rdw.be_n = mbus_ff.be_n;
            for (int i = 0; i < `LANES; i++) begin
              nxt_rdw.data[8*i +: 8] = mbus_ff.be_n[i] ? 8'h00 : i_bus_rdata[8*i +: 8];  // [RULE12]
            end
          end
          nxt_mst = (left_ff == 16'(beat_n)) ? M_REL : M_T1;
        end
      end
      M_REL: begin
        nxt_hold      = 1'b0;  // [RULE16]
        nxt_oe_n      = 1'b1;
        nxt_mbus.be_n = `BE_IDLE;
        nxt_mst       = M_IDLE;
      end
      default: nxt_mst = M_IDLE;
    endcase
  end

  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      mst_ff    <= M_IDLE;
      addr_ff   <= '0;
      left_ff   <= 16'h0000;
      wr_ff     <= 1'b0;
      hold_ff   <= 1'b0;
      oe_n_ff   <= 1'b1;
      ads_ff    <= 1'b0;
      mbus_ff   <= '{addr: '0, be_n: `BE_IDLE, wdata: '0, write: 1'b0};
      rdw_ff    <= '0;
      rd_stb_ff <= 1'b0;
    end else begin
      mst_ff    <= nxt_mst;
      addr_ff   <= nxt_addr;
      left_ff   <= nxt_left;
      wr_ff     <= nxt_wr;
      hold_ff   <= nxt_hold;
      oe_n_ff   <= nxt_oe_n;
      ads_ff    <= nxt_ads;
      mbus_ff   <= nxt_mbus;
      rdw_ff    <= nxt_rdw;
      rd_stb_ff <= nxt_rd_stb;
    end
  end

  // phase clock copy, registered
  logic phase_clk_ff;
  logic busy_ff;

  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      phase_clk_ff <= 1'b0;
      busy_ff      <= 1'b0;
    end else begin
      phase_clk_ff <= phase2;  // high during next phase one
      busy_ff      <= (nxt_mst != M_IDLE);
    end
  end

  assign o_ready_out    = rdy_ff;
  assign o_slave_wr     = swr_ff;
  assign o_slave_wr_stb = swr_stb_ff;
  assign o_slave_rdata  = srd_ff;
  assign o_hold_req     = hold_ff;
  assign o_mbus         = mbus_ff;
  assign o_mbus_oe_n    = oe_n_ff;
  assign o_addr_strobe  = ads_ff;
  assign o_xfer_busy    = busy_ff;
  assign o_rd_word      = rdw_ff;
  assign o_rd_stb       = rd_stb_ff;
  assign o_phase_clk    = phase_clk_ff;

endmodule : host_bus_port
`default_nettype wire

// >>> bench/host_bus_port_assertions.sv
// checker: slave wait, capture, master handshake, release and phase order
// assumes binding to host_bus_port, one clock, async active-low reset
`timescale 1ns/1ns
`default_nettype none
`include "host_port_defines.svh"
module host_bus_port_checker #(
  parameter int WAITS = 2
) (
  // clock and reset
  input wire logic                          i_core_clk,
  input wire logic                          i_rstn,
  // slave side
  input wire logic                          i_slave_sel,
  input wire logic [`LANES-1:0]             i_slave_be_n,
  input wire logic                          i_ready_in,
  input wire logic                          o_ready_out,
  input wire host_port_pkg::lane_word_type  o_slave_wr,
  input wire logic                          o_slave_wr_stb,
  // master side
  input wire logic                          o_hold_req,
  input wire logic                          i_bus_grant_ack,
  input wire host_port_pkg::master_bus_type o_mbus,
  input wire logic                          o_mbus_oe_n,
  input wire logic                          o_rd_stb,
  input wire logic                          o_phase_clk
);
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rstn);
  slave_wait_a: assert property ($rose(i_slave_sel) |-> !o_ready_out [*4] ##[1:6] o_ready_out)
    else $error("slave ready outside wait window");
  wr_capture_a: assert property (o_slave_wr_stb |-> o_ready_out && o_slave_wr.be_n == $past(i_slave_be_n))
    else $error("write capture not on ready edge");
  master_ready_a: assert property (o_rd_stb |-> $past(i_ready_in))
    else $error("master beat ended without ready");
  grant_first_a: assert property ($fell(o_mbus_oe_n) |-> $past(i_bus_grant_ack) && o_hold_req)
    else $error("bus driven before grant");
  word_addr_a: assert property (!o_mbus_oe_n |-> o_mbus.addr[1:0] == 2'h0)
    else $error("master address not longword");
  bus_release_a: assert property ($fell(o_hold_req) |-> o_mbus_oe_n && o_mbus.be_n == 4'hf)
    else $error("bus not released with hold");
  phase_alt_a: assert property (o_phase_clk |=> !o_phase_clk ##1 o_phase_clk)
    else $error("phase clock not halved");
  phase_start_a: assert property ($rose(i_rstn) |-> !o_phase_clk ##[2:3] o_phase_clk)
    else $error("first phase one late or early");
endmodule : host_bus_port_checker
bind host_bus_port host_bus_port_checker #(.WAITS(WAITS)) i_host_bus_port_checker (.*);
`default_nettype wire

// >>> bench/host_bus_model.sv
// far side: arbiter, longword memory with wait count, ready routing
// assumes device outputs registered on i_core_clk
`timescale 1ns/1ns
`default_nettype none
module host_bus_model (
  // clock and reset
  input  wire logic                          i_core_clk,
  input  wire logic                          i_rstn,
  // device outputs
  input  wire logic                          i_hold_req,
  input  wire host_port_pkg::master_bus_type i_mbus,
  input  wire logic                          i_oe_n,
  input  wire logic                          i_strobe,
  input  wire logic                          i_ready_out,
  // host stimulus
  input  wire logic [3:0]                    i_waits,
  input  wire logic [31:0]                   i_host_data,
  input  wire logic                          i_host_drv,
  // answers
  output logic                               o_grant,
  output logic                               o_ready_in,
  output logic [31:0]                        o_rdata
);
  logic [3:0]  cnt_ff;
  logic        pend_ff;
  logic        rdy_ff;
  logic [31:0] last_ff;
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_grant <= 1'h0;
      cnt_ff  <= 4'h0;
      pend_ff <= 1'h0;
      rdy_ff  <= 1'h0;
      last_ff <= 32'h0;
    end else begin
      o_grant <= i_hold_req;
      last_ff <= o_rdata;
      if (i_strobe) begin
        cnt_ff  <= i_waits;
        pend_ff <= !i_oe_n;
        rdy_ff  <= 1'h0;
      end else if (pend_ff && cnt_ff != 4'h0) cnt_ff <= cnt_ff - 4'h1;
      else if (pend_ff) begin
        pend_ff <= 1'h0;
        rdy_ff  <= 1'h1;
      end else if (i_oe_n) rdy_ff <= 1'h0;
    end
  end
  // slave ready seen exactly as the host sees it
  assign o_ready_in = i_ready_out | (rdy_ff & !i_strobe);
  // undriven bus flips every cycle
  assign o_rdata = (!i_oe_n && !i_mbus.write) ? (i_mbus.addr ^ 32'ha5a5_5a5a) : i_host_drv ? i_host_data : ~last_ff;
endmodule : host_bus_model
`default_nettype wire

// >>> bench/tb.sv
// testbench: slave cycles, lane writes, unaligned master transfers
// assumes host_bus_model on the far side and the bound checker
`timescale 1ns/1ns
`default_nettype none
module tb;
  logic i_core_clk = 1'h0, i_rstn = 1'h0, i_slave_sel = 1'h0, i_slave_write = 1'h0;
  logic i_xfer_start = 1'h0, host_drv = 1'h0, i_ready_in, i_bus_grant_ack, o_ready_out, o_slave_wr_stb;
  logic o_hold_req, o_mbus_oe_n, o_addr_strobe, o_xfer_busy, o_rd_stb, o_phase_clk;
  logic [3:0]  i_slave_be_n = 4'hf, waits = 4'h0;
  logic [31:0] i_bus_rdata, o_slave_rdata, host_data = 32'h0;
  logic [31:0] i_reg_rdata = 32'hc3c3_5a5a, i_xfer_wdata = 32'h1357_9bdf;
  host_port_pkg::lane_word_type  o_slave_wr, o_rd_word;
  host_port_pkg::master_bus_type o_mbus;
  host_port_pkg::xfer_req_type   i_xfer = '0;
  int mismatches = 0;
  int total_checks = 0;
  always #2 i_core_clk = ~i_core_clk;
  host_bus_port #(.WAITS(2)) i_host_bus_port (.*);
  host_bus_model i_host_bus_model (.i_core_clk(i_core_clk), .i_rstn(i_rstn), .i_hold_req(o_hold_req),
    .i_mbus(o_mbus), .i_oe_n(o_mbus_oe_n), .i_strobe(o_addr_strobe), .i_ready_out(o_ready_out),
    .i_waits(waits), .i_host_data(host_data), .i_host_drv(host_drv), .o_grant(i_bus_grant_ack),
    .o_ready_in(i_ready_in), .o_rdata(i_bus_rdata));
  task automatic check(input logic [68:0] seen, input logic [68:0] exp);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic close_out();
    if (mismatches == 0 && total_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : close_out
  task automatic slave_cycle(input logic w, input logic [3:0] be, input logic [31:0] d, input logic [31:0] exp);
    int n;
    n = 0;
    i_slave_sel <= 1'h1;
    i_slave_write <= w;
    i_slave_be_n <= be;
    host_data <= d;
    host_drv <= w;
    do begin
      @(negedge i_core_clk);
      n++;
    end while (o_ready_out !== 1'h1 && n < 40);
    if (n >= 40) begin
      mismatches++;
      close_out();
    end
    check(n >= 5 && n <= 10, 1'h1);
    check(o_slave_wr_stb, w);
    check(o_phase_clk, 1'h1);
    if (w) check(o_slave_wr, {exp, be});
    else check(o_slave_rdata, exp);
    @(posedge i_core_clk);
    i_slave_sel <= 1'h0;
    host_drv <= 1'h0;
    @(posedge i_core_clk);
  endtask : slave_cycle
  task automatic master_xfer(input logic [31:0] a, input logic [15:0] cnt, input logic w, input logic [3:0] wt);
    logic [31:0] pos, word, msk;
    logic [3:0]  be;
    int left, k, n, tail, sb, rb;
    pos = a;
    left = cnt;
    {n, tail, sb, rb, word, msk, be} = '0;
    waits <= wt;
    i_xfer <= {a, cnt, w};
    i_xfer_start <= 1'h1;
    @(posedge i_core_clk);
    i_xfer_start <= 1'h0;
    while (n < 400 && tail < 3) begin
      @(negedge i_core_clk);
      n++;
      if (o_addr_strobe === 1'h1) begin
        word = {pos[31:2], 2'h0};
        be = 4'hf;
        msk = 32'h0;
        sb++;
        for (k = pos[1:0]; k < 4 && left > 0; k++) begin
          be[k] = 1'h0;
          msk[8*k +: 8] = 8'hff;
          left--;
          pos++;
        end
        check(o_mbus.addr, word);
        check(o_mbus.be_n, be);
        check({o_mbus.write, o_mbus.wdata & msk}, {w, i_xfer_wdata & msk});
      end
      if (o_rd_stb === 1'h1) begin
        rb++;
        check(o_rd_word, {(word ^ 32'ha5a5_5a5a) & msk, be});
      end
      if (left == 0 && o_xfer_busy !== 1'h1) tail++;
    end
    if (n >= 400) begin
      mismatches++;
      close_out();
    end
    check(rb, w ? 0 : sb);
    check({o_hold_req, o_mbus_oe_n, o_mbus.be_n}, 6'h1f);
    @(posedge i_core_clk);
  endtask : master_xfer
  initial begin
    repeat (5) @(posedge i_core_clk);
    i_rstn <= 1'h1;
    repeat (8) @(posedge i_core_clk);
    slave_cycle(1'h1, 4'h0, 32'h1111_2222, 32'h1111_2222);
    slave_cycle(1'h1, 4'h5, 32'haaaa_bbbb, 32'haa11_bb22);
    slave_cycle(1'h1, 4'hf, 32'h5555_6666, 32'haa11_bb22);
    slave_cycle(1'h0, 4'h0, 32'h0, 32'hc3c3_5a5a);
    master_xfer(32'h0000_1001, 16'h0009, 1'h0, 4'h0);
    master_xfer(32'h0000_2000, 16'h0008, 1'h0, 4'h3);
    master_xfer(32'h0000_3003, 16'h0006, 1'h1, 4'h1);
    master_xfer(32'h0000_4002, 16'h0001, 1'h0, 4'h0);
    close_out();
  end
endmodule : tb
`default_nettype wire
